// [pdmac_axil_slave.sv]
// axi4-lite slave turning bus transfers into single-cycle register strobes
`timescale 1ns/100ps
module pdmac_axil_slave
  import pdmac_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [PDMAC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [PDMAC_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [PDMAC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [PDMAC_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  pdmac_reg_if.bus                     rif
);

  logic                    aw_held_q;
  logic                    w_held_q;
  logic                    ar_held_q;
  logic [PDMAC_ADDR_W-1:0] awaddr_q;
  logic [PDMAC_ADDR_W-1:0] araddr_q;
  logic [PDMAC_DATA_W-1:0] wdata_q;
  logic [3:0]              wstrb_q;

  // address and data may arrive in either order; each is held until both are in
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !ar_held_q && !s_axi_rvalid;

  assign rif.wr_en   = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rif.wr_addr = awaddr_q;
  assign rif.wr_data = wdata_q;
  assign rif.wr_strb = wstrb_q;
  assign rif.rd_en   = ar_held_q && !s_axi_rvalid;
  assign rif.rd_addr = araddr_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (rif.wr_en) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (rif.wr_en) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PDMAC_RESP_OKAY;
    end else if (rif.wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= rif.wr_err ? PDMAC_RESP_SLVERR : PDMAC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_held_q <= 1'b0;
      araddr_q  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_held_q <= 1'b1;
      araddr_q  <= s_axi_araddr;
    end else if (rif.rd_en) begin
      ar_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= PDMAC_RST_WORD;
      s_axi_rresp  <= PDMAC_RESP_OKAY;
    end else if (rif.rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rif.rd_data;
      s_axi_rresp  <= rif.rd_err ? PDMAC_RESP_SLVERR : PDMAC_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [pdmac_dma_irq_ctrl.sv]
// priority class, channel arbitration, flag and interrupt registers of the dma
// Summary of operation
// - writing one returns channel to round-robin
// - clear register write-only; read class elsewhere
// - per-channel enable gates channel flags into interrupt; events use own mask
// - channels 0,1 timeout flags, write-one clears
// - status bit 2 summarises table-empty flags
// - status bit 1 summarises done flags
// - status bit 0 summarises abort flags
// - status register at 0x41C resets zero
// - fixed beats round-robin; higher channel first
// - done flag per channel, write-one clears
// - abort flag per channel, write-one clears
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
module pdmac_dma_irq_ctrl
  import pdmac_pkg::*;
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [PDMAC_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [PDMAC_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [PDMAC_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [PDMAC_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [PDMAC_NUM_CHAN-1:0] chan_request,
  input  wire logic                      arb_advance,
  input  wire logic [PDMAC_NUM_CHAN-1:0] chan_done_pulse,
  input  wire logic [PDMAC_NUM_CHAN-1:0] chan_abort_pulse,
  input  wire logic [PDMAC_NUM_CHAN-1:0] table_empty_pulse,
  input  wire logic [PDMAC_NUM_TO-1:0]   req_timeout_pulse,
  output logic [PDMAC_NUM_CHAN-1:0]      chan_grant,
  output logic                           chan_grant_valid,
  output logic [PDMAC_NUM_CHAN-1:0]      fixed_prio_class,
  output logic                           dma_irq
);

  pdmac_reg_if rif ();

  pdmac_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rif           (rif.bus)
  );

  pdmac_chan_type               fixed_prio_set_bit_q;
  pdmac_chan_type               chan_irq_enable_q;
  pdmac_chan_type               abort_flag_q;
  pdmac_chan_type               done_flag_q;
  pdmac_chan_type               empty_flag_q;
  logic [PDMAC_NUM_TO-1:0]      request_timeout_flag_q;
  logic [PDMAC_EVT_W-1:0]       evt_sts_q;
  logic [PDMAC_EVT_W-1:0]       evt_mask_q;
  logic [PDMAC_EVT_W-1:0]       evt_set;
  logic                         irq_q;
  pdmac_chan_type               chan_pend;
  logic                         table_empty_summary;
  logic                         transfer_done_summary;
  logic                         target_abort_summary;
  logic [31:0]                  wmask;
  logic [31:0]                  wval;
  logic [9:0]                   wr_word;
  logic [9:0]                   rd_word;
  logic                         hit_prio_set;
  logic                         hit_prio_clr;
  logic                         hit_inten;
  logic                         hit_intsts;
  logic                         hit_abort;
  logic                         hit_done;
  logic                         hit_empty;
  logic                         hit_evt_mask;
  logic                         rd_evt_clear;
  logic [31:0]                  intsts_word;
  pdmac_chan_type               fixed_req;
  pdmac_chan_type               rr_req;
  pdmac_chan_type               rr_below;
  logic [2:0]                   rr_ptr_q;
  logic [2:0]                   win_idx;
  logic                         win_found;
  logic                         win_fixed;
  logic [2:0]                   grant_idx_q;
  logic                         grant_fixed_q;
  pdmac_chan_type               grant_d;

  // highest set bit wins; returns all zeros, valid bit clear, when nothing is set
  function automatic logic [3:0] pdmac_highest(input pdmac_chan_type v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < PDMAC_NUM_CHAN; i++) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // byte lanes: only lanes 0 and 1 hold implemented bits
  assign wmask   = {{8{rif.wr_strb[3]}}, {8{rif.wr_strb[2]}},
                    {8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}};
  assign wval    = rif.wr_data & wmask;
  assign wr_word = rif.wr_addr[11:2];
  assign rd_word = rif.rd_addr[11:2];

  assign hit_prio_set = rif.wr_en && (wr_word == PDMAC_OFF_PRIO_SET[11:2]);
  assign hit_prio_clr = rif.wr_en && (wr_word == PDMAC_OFF_PRIO_CLR[11:2]);
  assign hit_inten    = rif.wr_en && (wr_word == PDMAC_OFF_INTEN[11:2]);
  assign hit_intsts   = rif.wr_en && (wr_word == PDMAC_OFF_INTSTS[11:2]);
  assign hit_abort    = rif.wr_en && (wr_word == PDMAC_OFF_ABORT_STS[11:2]);
  assign hit_done     = rif.wr_en && (wr_word == PDMAC_OFF_DONE_STS[11:2]);
  assign hit_empty    = rif.wr_en && (wr_word == PDMAC_OFF_EMPTY_STS[11:2]);
  assign hit_evt_mask = rif.wr_en && (wr_word == PDMAC_OFF_EVT_MASK[11:2]);
  assign rd_evt_clear = rif.rd_en && (rd_word == PDMAC_OFF_EVT_STS[11:2]);

  // the read-clear event register accepts writes but ignores them
  assign rif.wr_err = !(hit_prio_set || hit_prio_clr || hit_inten || hit_intsts ||
                        hit_abort || hit_done || hit_empty || hit_evt_mask ||
                        (wr_word == PDMAC_OFF_EVT_STS[11:2]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fixed_prio_set_bit_q <= PDMAC_RST_CHAN;
    end else if (hit_prio_set) begin
      fixed_prio_set_bit_q <= fixed_prio_set_bit_q | wval[PDMAC_NUM_CHAN-1:0];
    end else if (hit_prio_clr) begin
      fixed_prio_set_bit_q <= fixed_prio_set_bit_q & ~wval[PDMAC_NUM_CHAN-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_irq_enable_q <= PDMAC_RST_CHAN;
    end else if (hit_inten) begin
      chan_irq_enable_q <= (chan_irq_enable_q & ~wmask[PDMAC_NUM_CHAN-1:0]) |
                           wval[PDMAC_NUM_CHAN-1:0];
    end
  end

  // flags: a hardware set in the same cycle as a write-one clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      request_timeout_flag_q <= PDMAC_RST_TO;
    end else begin
      request_timeout_flag_q <= (request_timeout_flag_q &
        ~(hit_intsts ? wval[PDMAC_STS_TO_LSB +: PDMAC_NUM_TO] : PDMAC_RST_TO)) |
        req_timeout_pulse;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_flag_q <= PDMAC_RST_CHAN;
    end else begin
      abort_flag_q <= (abort_flag_q &
        ~(hit_abort ? wval[PDMAC_NUM_CHAN-1:0] : PDMAC_RST_CHAN)) |
        chan_abort_pulse;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag_q <= PDMAC_RST_CHAN;
    end else begin
      done_flag_q <= (done_flag_q &
        ~(hit_done ? wval[PDMAC_NUM_CHAN-1:0] : PDMAC_RST_CHAN)) |
        chan_done_pulse;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      empty_flag_q <= PDMAC_RST_CHAN;
    end else begin
      empty_flag_q <= (empty_flag_q &
        ~(hit_empty ? wval[PDMAC_NUM_CHAN-1:0] : PDMAC_RST_CHAN)) |
        table_empty_pulse;
    end
  end

  assign table_empty_summary   = |empty_flag_q;
  assign transfer_done_summary = |done_flag_q;
  assign target_abort_summary  = |abort_flag_q;

  always_comb begin
    intsts_word = PDMAC_RST_WORD;
    intsts_word[PDMAC_STS_TO_LSB +: PDMAC_NUM_TO] = request_timeout_flag_q;
    intsts_word[PDMAC_STS_EMPTY_BIT] = table_empty_summary;
    intsts_word[PDMAC_STS_DONE_BIT]  = transfer_done_summary;
    intsts_word[PDMAC_STS_ABORT_BIT] = target_abort_summary;
  end

  // read-clear event capture; a new event in the clearing read's cycle survives
  assign evt_set[PDMAC_EVT_DONE]    = |chan_done_pulse;
  assign evt_set[PDMAC_EVT_ABORT]   = |chan_abort_pulse;
  assign evt_set[PDMAC_EVT_EMPTY]   = |table_empty_pulse;
  assign evt_set[PDMAC_EVT_TIMEOUT] = |req_timeout_pulse;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_sts_q <= PDMAC_RST_EVT;
    end else begin
      evt_sts_q <= (rd_evt_clear ? PDMAC_RST_EVT : evt_sts_q) | evt_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_mask_q <= PDMAC_RST_EVT;
    end else if (hit_evt_mask) begin
      evt_mask_q <= (evt_mask_q & ~wmask[PDMAC_EVT_W-1:0]) | wval[PDMAC_EVT_W-1:0];
    end
  end

  for (genvar n = 0; n < PDMAC_NUM_CHAN; n++) begin : g_pend
    if (n < PDMAC_NUM_TO) begin : g_to
      assign chan_pend[n] = chan_irq_enable_q[n] && (done_flag_q[n] || abort_flag_q[n] ||
                            empty_flag_q[n] || request_timeout_flag_q[n]);
    end else begin : g_noto
      assign chan_pend[n] = chan_irq_enable_q[n] && (done_flag_q[n] || abort_flag_q[n] ||
                            empty_flag_q[n]);
    end
    assign rr_below[n] = (3'(n) < rr_ptr_q);
  end

  // registered so the line is glitch free; it lags its cause by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|chan_pend) || (|(evt_sts_q & evt_mask_q));
    end
  end

  assign dma_irq          = irq_q;
  assign fixed_prio_class = fixed_prio_set_bit_q;

  always_comb begin
    rif.rd_data = PDMAC_RST_WORD;
    rif.rd_err  = 1'b0;
    unique case (rd_word)
      PDMAC_OFF_PRIO_SET[11:2]:  rif.rd_data[PDMAC_NUM_CHAN-1:0] = fixed_prio_set_bit_q;
      PDMAC_OFF_PRIO_CLR[11:2]:  rif.rd_data = PDMAC_RST_WORD;
      PDMAC_OFF_INTEN[11:2]:     rif.rd_data[PDMAC_NUM_CHAN-1:0] = chan_irq_enable_q;
      PDMAC_OFF_INTSTS[11:2]:    rif.rd_data = intsts_word;
      PDMAC_OFF_ABORT_STS[11:2]: rif.rd_data[PDMAC_NUM_CHAN-1:0] = abort_flag_q;
      PDMAC_OFF_DONE_STS[11:2]:  rif.rd_data[PDMAC_NUM_CHAN-1:0] = done_flag_q;
      PDMAC_OFF_EMPTY_STS[11:2]: rif.rd_data[PDMAC_NUM_CHAN-1:0] = empty_flag_q;
      PDMAC_OFF_EVT_STS[11:2]:   rif.rd_data[PDMAC_EVT_W-1:0] = evt_sts_q;
      PDMAC_OFF_EVT_MASK[11:2]:  rif.rd_data[PDMAC_EVT_W-1:0] = evt_mask_q;
      default:                   rif.rd_err = 1'b1;
    endcase
  end

  // arbitration: fixed class first, then round-robin searching downward
  assign fixed_req = chan_request & fixed_prio_set_bit_q;
  assign rr_req    = chan_request & ~fixed_prio_set_bit_q;

  always_comb begin
    logic [3:0] hf;
    logic [3:0] hb;
    logic [3:0] ha;
    hf = pdmac_highest(fixed_req);
    hb = pdmac_highest(rr_req & rr_below);
    ha = pdmac_highest(rr_req);
    win_fixed = hf[3];
    if (hf[3]) begin
      win_found = 1'b1;
      win_idx   = hf[2:0];
    end else if (hb[3]) begin
      win_found = 1'b1;
      win_idx   = hb[2:0];
    end else begin
      win_found = ha[3];
      win_idx   = ha[2:0];
    end
    grant_d = PDMAC_RST_CHAN;
    if (win_found) begin
      grant_d[win_idx] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_grant       <= PDMAC_RST_CHAN;
      chan_grant_valid <= 1'b0;
      grant_idx_q      <= 3'h0;
      grant_fixed_q    <= 1'b0;
    end else begin
      chan_grant       <= grant_d;
      chan_grant_valid <= win_found;
      grant_idx_q      <= win_idx;
      grant_fixed_q    <= win_fixed;
    end
  end

  // pointer moves only when a round-robin grant is consumed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rr_ptr_q <= PDMAC_RST_RR_PTR;
    end else if (arb_advance && chan_grant_valid && !grant_fixed_q) begin
      rr_ptr_q <= grant_idx_q;
    end
  end

endmodule

// [pdmac_dma_irq_ctrl_chk.sv]
// port-level assertions for the dma priority and interrupt control slice
`timescale 1ns/100ps
module pdmac_dma_irq_ctrl_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [4:0] chan_request,
  input wire logic [4:0] chan_grant,
  input wire logic       chan_grant_valid,
  input wire logic [4:0] fixed_prio_class
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped early");
  property p_awblk; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_awblk: assert property (p_awblk) else $error("awready during bvalid");
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("arready during rvalid");
  property p_rlat; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_gone; |chan_request |=> chan_grant_valid && $onehot(chan_grant); endproperty
  a_gone: assert property (p_gone) else $error("grant not one-hot");
  property p_gsub; chan_grant_valid |-> (chan_grant & ~$past(chan_request)) == 5'h00; endproperty
  a_gsub: assert property (p_gsub) else $error("grant without request");
  property p_gfix; |(chan_request & fixed_prio_class) |=> |(chan_grant & $past(fixed_prio_class));
  endproperty
  a_gfix: assert property (p_gfix) else $error("fixed channel lost");
  property p_gnone; !(|chan_request) |=> !chan_grant_valid; endproperty
  a_gnone: assert property (p_gnone) else $error("grant with no request");
endmodule

// [pdmac_dma_irq_ctrl_tb.sv]
// self-checking bench for the dma priority and interrupt control slice
`timescale 1ns/100ps
module pdmac_dma_irq_ctrl_tb
  import pdmac_pkg::*;
();
  logic        aclk = 0, aresetn = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, adv = 0;
  logic [11:0] aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, r_d, rd;
  logic [4:0]  req = 0, dp = 0, ap = 0, ep = 0, gnt, cls;
  logic [1:0]  tp = 0, b_rsp, r_rsp, rs, tm = 0;
  logic        aw_r, w_r, b_v, ar_r, r_v, gv, irq, av = 0;
  logic [4:0]  pm = 0, en = 0, dm = 0, am = 0, em = 0, g = 0, rq = 0;
  logic [3:0]  ev = 0, mk = 0, ws = 4'hF, sb = 4'hF;
  int          mismatches = 0, checks_done = 0, cyc = 0, p = 5, np;
  logic [11:0] al [10] = '{12'h410, 12'h414, 12'h418, 12'h41C, 12'h420,
                           12'h424, 12'h428, 12'h430, 12'h434, 12'h500};
  pdmac_dma_irq_ctrl i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(ws), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_rsp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
    .s_axi_rresp(r_rsp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .chan_request(req),
    .arb_advance(adv), .chan_done_pulse(dp), .chan_abort_pulse(ap),
    .table_empty_pulse(ep), .req_timeout_pulse(tp), .chan_grant(gnt),
    .chan_grant_valid(gv), .fixed_prio_class(cls), .dma_irq(irq));
  initial forever #2.5 aclk = ~aclk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far above the roughly thirteen hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(bit wr, logic [11:0] a, logic [31:0] d);
    bit dn;
    int hold;
    hold = $urandom % 5;
    @(posedge aclk);
    if (wr) begin
      aw_a <= a; w_d <= d; ws <= sb; aw_v <= 1'b1; w_v <= 1'b1; b_r <= (hold == 0);
    end else begin
      ar_a <= a; ar_v <= 1'b1; r_r <= (hold == 0);
    end
    // each channel released on its own ready; a late ready makes the answer wait
    do begin
      @(posedge aclk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
      if (ar_r) ar_v <= 1'b0;
      dn = wr ? (b_v && b_r) : (r_v && r_r);
      if (hold > 0) begin
        hold--;
      end else if (!dn) begin
        b_r <= wr;
        r_r <= !wr;
      end
    end while (!dn);
    b_r <= 1'b0; r_r <= 1'b0; rd = r_d; rs = wr ? b_rsp : r_rsp;
  endtask
  function automatic logic [31:0] exv(logic [11:0] a);
    case (a)
      12'h410: return {27'h0, pm};
      12'h418: return {27'h0, en};
      12'h41C: return {22'h0, tm, 5'h00, |em, |dm, |am};
      12'h420: return {27'h0, am};
      12'h424: return {27'h0, dm};
      12'h428: return {27'h0, em};
      12'h430: return {28'h0, ev};
      12'h434: return {28'h0, mk};
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [1:0] ers(logic [11:0] a);
    return (a inside {[12'h410:12'h428], 12'h430, 12'h434}) ? 2'h0 : 2'h2;
  endfunction
  task automatic rdc(logic [11:0] a);
    logic [31:0] e;
    e = exv(a);
    bus(1'b0, a, 32'h0);
    cmp("rdata", e, rd);
    cmp("rresp", {30'h0, ers(a)}, {30'h0, rs});
    if (a == 12'h430) ev = 4'h0;
  endtask
  task automatic wrc(logic [11:0] a, logic [31:0] d);
    logic [31:0] m;
    m = d & {{8{sb[3]}}, {8{sb[2]}}, {8{sb[1]}}, {8{sb[0]}}};
    bus(1'b1, a, d);
    cmp("bresp", {30'h0, ers(a)}, {30'h0, rs});
    case (a)
      12'h410: pm |= m[4:0];
      12'h414: pm &= ~m[4:0];
      12'h418: en = sb[0] ? d[4:0] : en;
      12'h41C: tm &= ~m[9:8];
      12'h420: am &= ~m[4:0];
      12'h424: dm &= ~m[4:0];
      12'h428: em &= ~m[4:0];
      12'h434: mk = sb[0] ? d[3:0] : mk;
      default: ;
    endcase
  endtask
  task automatic pls(logic [4:0] d, logic [4:0] a, logic [4:0] e, logic [1:0] t);
    @(posedge aclk);
    dp <= d; ap <= a; ep <= e; tp <= t;
    @(posedge aclk);
    dp <= 5'h00; ap <= 5'h00; ep <= 5'h00; tp <= 2'h0;
    dm |= d; am |= a; em |= e; tm |= t;
    ev |= {|t, |e, |a, |d};
  endtask
  task automatic irqc();
    repeat (3) @(posedge aclk);
    cmp("irq", {31'h0, (|(en & (dm | am | em | {3'h0, tm}))) || (|(ev & mk))}, {31'h0, irq});
  endtask
  function automatic logic [4:0] arb(logic [4:0] r, logic [4:0] c, int p);
    logic [4:0] f, b;
    f = 5'h00;
    b = 5'h00;
    for (int i = 0; i < 5; i++) begin
      if (r[i] && c[i]) f = 5'h01 << i;
      if (r[i]) b = 5'h01 << i;
    end
    if (f != 5'h00) return f;
    for (int i = 0; i < p; i++) if (r[i]) f = 5'h01 << i;
    return (f != 5'h00) ? f : b;
  endfunction
  initial begin
    void'($urandom(32'hB2140E22));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++) rdc(al[i]);
    wrc(12'h410, $urandom);
    rdc(12'h410);
    wrc(12'h414, $urandom);
    rdc(12'h410);
    rdc(12'h414);
    cmp("class", {27'h0, pm}, {27'h0, cls});
    for (int ph = 0; ph < 2; ph++) begin
      if (ph == 1) wrc(12'h414, 32'h0000_001F);
      // last step idles the arbiter so the model stays aligned across writes
      for (int k = 0; k < 200; k++) begin
        @(posedge aclk);
        np = (av && g != 5'h00 && (g & pm) == 5'h00) ? $clog2(g) : p;
        g = arb(rq, pm, p);
        p = np;
        rq = (k == 199) ? 5'h00 : 5'($urandom);
        av = (k < 199) && 1'($urandom);
        req <= rq;
        adv <= av;
        #1;
        cmp("grant", {26'h0, g != 5'h00, g}, {26'h0, gv, gnt});
      end
    end
    wrc(12'h418, $urandom);
    wrc(12'h500, $urandom);
    for (int k = 0; k < 16; k++) begin
      sb = 4'($urandom);
      pls(5'($urandom), 5'($urandom), 5'($urandom), 2'($urandom));
      if (k == 8) wrc(12'h434, $urandom);
      irqc();
      for (int j = 2; j < 8; j++) rdc(al[j]);
      wrc(al[3 + k % 4], $urandom);
      if (k % 5 == 4) wrc(12'h418, $urandom);
      irqc();
    end
    // second reset in mid-run: every flag, enable and class must come back clear
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    {pm, en, dm, am, em, tm, ev, mk} = '0;
    irqc();
    for (int i = 0; i < 10; i++) rdc(al[i]);
    wrap_up();
  end
endmodule
bind pdmac_dma_irq_ctrl pdmac_dma_irq_ctrl_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .chan_request(chan_request), .chan_grant(chan_grant),
  .chan_grant_valid(chan_grant_valid), .fixed_prio_class(fixed_prio_class));

// [pdmac_pkg.sv]
// constants and types shared by the dma priority and interrupt control slice
package pdmac_pkg;

  localparam int unsigned PDMAC_NUM_CHAN = 5;
  localparam int unsigned PDMAC_NUM_TO   = 2;
  localparam int unsigned PDMAC_ADDR_W   = 12;
  localparam int unsigned PDMAC_DATA_W   = 32;

  localparam logic [11:0] PDMAC_OFF_PRIO_SET   = 12'h410;
  localparam logic [11:0] PDMAC_OFF_PRIO_CLR   = 12'h414;
  localparam logic [11:0] PDMAC_OFF_INTEN      = 12'h418;
  localparam logic [11:0] PDMAC_OFF_INTSTS     = 12'h41C;
  localparam logic [11:0] PDMAC_OFF_ABORT_STS  = 12'h420;
  localparam logic [11:0] PDMAC_OFF_DONE_STS   = 12'h424;
  localparam logic [11:0] PDMAC_OFF_EMPTY_STS  = 12'h428;
  localparam logic [11:0] PDMAC_OFF_EVT_STS    = 12'h430;
  localparam logic [11:0] PDMAC_OFF_EVT_MASK   = 12'h434;

  localparam int unsigned PDMAC_STS_ABORT_BIT  = 0;
  localparam int unsigned PDMAC_STS_DONE_BIT   = 1;
  localparam int unsigned PDMAC_STS_EMPTY_BIT  = 2;
  localparam int unsigned PDMAC_STS_TO_LSB     = 8;

  localparam int unsigned PDMAC_EVT_DONE       = 0;
  localparam int unsigned PDMAC_EVT_ABORT      = 1;
  localparam int unsigned PDMAC_EVT_EMPTY      = 2;
  localparam int unsigned PDMAC_EVT_TIMEOUT    = 3;
  localparam int unsigned PDMAC_EVT_W          = 4;

  localparam logic [4:0]  PDMAC_RST_CHAN       = 5'h00;
  localparam logic [1:0]  PDMAC_RST_TO         = 2'h0;
  localparam logic [3:0]  PDMAC_RST_EVT        = 4'h0;
  localparam logic [2:0]  PDMAC_RST_RR_PTR     = 3'h5;
  localparam logic [31:0] PDMAC_RST_WORD       = 32'h0000_0000;

  localparam logic [1:0]  PDMAC_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  PDMAC_RESP_SLVERR    = 2'h2;

  typedef logic [PDMAC_NUM_CHAN-1:0] pdmac_chan_type;

endpackage

// [pdmac_reg_if.sv]
// register access strobes between the bus slave and the register file
`timescale 1ns/100ps
interface pdmac_reg_if;
  import pdmac_pkg::*;

  logic                    wr_en;
  logic [PDMAC_ADDR_W-1:0] wr_addr;
  logic [PDMAC_DATA_W-1:0] wr_data;
  logic [3:0]              wr_strb;
  logic                    wr_err;
  logic                    rd_en;
  logic [PDMAC_ADDR_W-1:0] rd_addr;
  logic [PDMAC_DATA_W-1:0] rd_data;
  logic                    rd_err;

  modport bus (
    output wr_en,
    output wr_addr,
    output wr_data,
    output wr_strb,
    input  wr_err,
    output rd_en,
    output rd_addr,
    input  rd_data,
    input  rd_err
  );

  modport regs (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  wr_strb,
    output wr_err,
    input  rd_en,
    input  rd_addr,
    output rd_data,
    output rd_err
  );
endinterface
